// ### float_to_int_convert_bench.sv
`timescale 1ns/100ps
// Self-checking bench: a reference model in integers is compared with every result.
module float_to_int_convert_bench;
  import ftic_pkg::*;

  logic         clk;
  logic         rst_n;
  logic         clk_en;
  ftic_bus_t    bus;
  ftic_req_t    req;
  logic         fue;
  ftic_res_t    res;
  ftic_flags_t  status_flags;
  logic [31:0]  rd_data;
  logic [6:0]   fl;
  logic [2:0]   ctl;
  logic [63:0]  ops [14];
  int           bad_count;
  int           n_checks;
  int           seed_ret;

  ftic_pipe_model ftic_pipe_model_inst (.clk(clk), .req(req), .float_unit_enable(fue));

  ftic_convert ftic_convert_inst (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .float_unit_enable(fue), .req(req),
    .bus(bus), .res(res), .status_flags(status_flags), .rd_data(rd_data)
  );

  // Clock of 4 ns period.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts one comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (e !== g)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // Register write, one strobe cycle; the model tracks control and status.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    if (a == ADDR_CTRL) ctl = d[2:0];
    if (a == ADDR_STATUS) fl = d[6:0];
  endtask : bus_wr

  // Register read; data is looked at in the cycle after the strobe.
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    bus.addr <= ~a;
    #1;
    chk("rd_data", {32'h0000_0000, e}, {32'h0000_0000, rd_data});
  endtask : bus_rd

  // Reference conversion; f holds signaling NaN, invalid, inexact and rounded-up.
  function automatic void ref_conv(input logic [63:0] op, input logic wd, input logic [1:0] md,
                                   output logic [63:0] d, output logic [3:0] f);
    logic [10:0] e;
    logic [64:0] m;
    logic [64:0] lim;
    logic [64:0] v;
    logic        s;
    logic        g;
    logic        r;
    logic        x;
    logic        inc;
    int          sh;
    s = op[63];
    e = op[62:52];
    {g, r, x, inc} = 4'h0;
    lim = wd ? (65'h1 << 31) : (65'h1 << 63);
    if (e == EXP_ALL_ONES)
      f = (op[51:0] == 0 || op[51]) ? 4'h4 : 4'hc;
    else if (e > EXP_LARGE)
      f = 4'h4;
    else
    begin
      m = {1'b0, e != 0, op[51:0], 11'h000};
      sh = (e != 0) ? 1086 - int'(e) : 1085;
      if (sh > 68) sh = 68;
      for (int i = 0; i < sh; i++)
      begin
        x = x | r;
        r = g;
        g = m[0];
        m = m >> 1;
      end
      case (md)
        RM_NEAREST: inc = g & (m[0] | r | x);
        RM_UP:      inc = !s & (g | r | x);
        RM_DOWN:    inc = s & (g | r | x);
        default:    inc = 1'b0;
      endcase
      m = m + {64'h0000_0000_0000_0000, inc};
      f = (s ? m > lim : m > lim - 65'h1) ? 4'h4 : {2'b00, g | r | x, inc};
      v = s ? ~m + 65'h1 : m;
      d = wd ? {W_UPPER_FILL, v[31:0]} : v[63:0];
    end
    // Saturated default: NaN or negative gives the minimum, else the maximum.
    if (f[2])
      d = (s || (e == EXP_ALL_ONES && op[51:0] != 0)) ? (wd ? {W_UPPER_FILL, W_MIN} : DW_MIN)
                                                     : (wd ? {W_UPPER_FILL, W_MAX} : DW_MAX);
  endfunction : ref_conv

  // One conversion through the pipeline model, checked against the reference.
  task automatic conv(input logic [63:0] op, input logic wd, input logic tr, input logic rc, input logic fu);
    logic [63:0] d;
    logic [3:0]  f;
    logic        wr;
    ref_conv(op, wd, tr ? RM_ZERO : ctl[1:0], d, f);
    wr = fu && !(ctl[2] && f[2]);
    if (fu)
      fl = {fl[6] | (f[3] & !fl[4]) | (f[2] & !fl[3]) | (f[1] & !fl[2]), fl[5],
            fl[4] | f[3], fl[3] | f[2], fl[2] | f[1], f[1], f[0]};
    ftic_pipe_model_inst.issue(op, wd, tr, rc, fu);
    #1;
    chk("res_valid", 64'h1, {63'h0, res.valid});
    chk("res_unavail", {63'h0, !fu}, {63'h0, res.unavail});
    chk("res_write", {63'h0, wr}, {63'h0, res.write});
    if (wr) chk("res_data", d, res.data);
    chk("status_flags", {57'h0, fl}, {57'h0, status_flags});
    chk("cr1_valid", {63'h0, fu & wd & rc}, {63'h0, res.cr1_valid});
    if (fu && wd && rc)
      chk("cr1", {60'h0, fl[6], ctl[2] & (fl[4] | fl[3]), fl[4] | fl[3], fl[5]},
          {60'h0, res.condition_field_one});
  endtask : conv

  // Cuts a hang short.
  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  // Main sequence.
  initial
  begin
    ops = '{64'h3ff8_0000_0000_0000, 64'h4004_0000_0000_0000, 64'hc004_0000_0000_0000,
           64'hbfe0_0000_0000_0000, 64'h0000_0000_0000_0001, 64'h7ff0_0000_0000_0000,
           64'hfff0_0000_0000_0000, 64'h7ff0_0000_0000_0001, 64'h7ff8_0000_0000_0000,
           64'h43e0_0000_0000_0000, 64'hc3e0_0000_0000_0000, 64'h41df_ffff_ffe0_0000,
           64'hc1e0_0000_0000_0000, 64'h4400_0000_0000_0000};
    {bad_count, n_checks} = '0;
    {fl, ctl} = '0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    bus = '0;
    seed_ret = $urandom(26772);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus_rd(ADDR_CTRL, 32'h0000_0000);
    bus_rd(ADDR_STATUS, 32'h0000_0000);
    bus_rd(8'h08, 32'h0000_0000);
    $display("test reset done");
    conv(64'h3ff8_0000_0000_0000, 1'b0, 1'b0, 1'b0, 1'b1);
    $display("test walk done");
    // Every mode, both variants and both widths over the edge operands.
    for (int md = 0; md < 4; md++)
    begin
      bus_wr(ADDR_CTRL, 32'(md));
      for (int k = 0; k < 4; k++)
        foreach (ops[i]) conv(ops[i], k[0], k[1], 1'b1, 1'b1);
    end
    $display("test table done");
    bus_wr(ADDR_STATUS, 32'h0000_0020);
    conv(64'h4004_0000_0000_0000, 1'b1, 1'b0, 1'b1, 1'b1);
    bus_rd(ADDR_STATUS, {23'h0, fl[4] | fl[3], ctl[2] & (fl[4] | fl[3]), fl});
    $display("test status write done");
    // Clock enable low freezes the registers, so this write is lost.
    clk_en <= 1'b0;
    bus_wr(ADDR_CTRL, 32'h0000_0007);
    ctl = 3'h3;
    clk_en <= 1'b1;
    bus_rd(ADDR_CTRL, {29'h0, ctl});
    $display("test clock enable done");
    // Random operands near the range edges, random trap enable and unit availability.
    for (int n = 0; n < 300; n++)
    begin
      if (n % 8 == 0) bus_wr(ADDR_CTRL, 32'($urandom_range(0, 7)));
      if (n % 50 == 0) bus_wr(ADDR_STATUS, 32'h0000_0000);
      conv(({$urandom(), $urandom()} & 64'h800f_ffff_ffff_ffff) | {1'b0, 11'h3e8 + 11'($urandom_range(0, 120)), 52'h0},
           1'($urandom()), 1'($urandom()), 1'($urandom()), $urandom_range(0, 9) != 0);
    end
    bus_rd(ADDR_STATUS, {23'h0, fl[4] | fl[3], ctl[2] & (fl[4] | fl[3]), fl});
    $display("test random done");
    end_sim();
  end
endmodule : float_to_int_convert_bench

// ### ftic_convert.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module ftic_convert (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire logic                 float_unit_enable,
  input  wire ftic_pkg::ftic_req_t  req,
  input  wire ftic_pkg::ftic_bus_t  bus,
  output      ftic_pkg::ftic_res_t  res,
  output      ftic_pkg::ftic_flags_t status_flags,
  output      logic [31:0]          rd_data
);
  import ftic_pkg::*;

  logic [1:0]  rst_sync_q;
  logic        rst_sys_n;
  ftic_state_t s_q;
  ftic_state_t s_d;

  logic        sign;
  logic [10:0] expo;
  logic [51:0] fracf;
  logic        is_special;
  logic        is_inf;
  logic        is_snan;
  logic        is_qnan;
  logic        is_big;
  logic [11:0] sh_full;
  logic [6:0]  sh;
  logic [67:0] pre;
  logic [67:0] shifted;
  logic [67:0] lost_mask;
  logic        lost;
  logic        gbit;
  logic        rbit;
  logic        xbit;
  logic [64:0] aligned;
  logic [1:0]  round_mode;
  logic        inc;
  logic [64:0] mag;
  logic [64:0] signed_val;
  logic        dw_oor;
  logic        w_oor;
  logic        oor;
  logic        invalid;
  logic [63:0] dw_default;
  logic [31:0] w_default;
  logic [63:0] conv_data;
  logic        conv_rounded;
  logic        conv_inexact;
  logic        exec;
  logic        neg_nonzero;

  // Two-flop release of the asynchronous reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_sys_n = rst_sync_q[1];

  // Operand decode into sign, exponent, fraction and special classes.
  assign sign       = req.operand[63];
  assign expo       = req.operand[62:52];
  assign fracf      = req.operand[51:0];
  assign is_special = (expo == EXP_ALL_ONES);
  assign is_inf     = is_special && (fracf == 52'h0_0000_0000_0000);
  assign is_snan    = is_special && !fracf[51] && !is_inf;
  assign is_qnan    = is_special && fracf[51];
  assign is_big     = !is_special && (expo > EXP_LARGE);

  // Shift distance; denormals and tiny values clamp so all bits fold into sticky.
  assign sh_full = (expo == 11'h000) ? SHIFT_DENORM : (SHIFT_BASE - {1'b0, expo});
  assign sh      = (sh_full > SHIFT_MAX) ? SHIFT_MAX[6:0] : sh_full[6:0];

  // Significand with leading zero, hidden bit, fraction, padding and guard/round/sticky slots.
  assign pre       = {1'b0, (expo != 11'h000), fracf, 11'h000, 3'h0};
  assign shifted   = pre >> sh;
  assign lost_mask = ~({68{1'b1}} << sh);
  assign lost      = |(pre & lost_mask);
  assign gbit      = shifted[2];
  assign rbit      = shifted[1];
  assign xbit      = shifted[0] | lost;
  assign aligned   = shifted[67:3];

  // Truncating variants ignore the programmed rounding field.
  assign round_mode = req.trunc ? RM_ZERO
                                : s_q.ctrl.rounding_mode_field;

  // Increment decision per rounding mode.
  always_comb
  begin
    case (round_mode)
      RM_NEAREST: inc = gbit && (aligned[0] || rbit || xbit);
      RM_ZERO:    inc = 1'b0;
      RM_UP:      inc = !sign && (gbit || rbit || xbit);
      RM_DOWN:    inc = sign && (gbit || rbit || xbit);
      default:    inc = 1'b0;
    endcase
  end

  // Rounded magnitude, then two's complement for negative operands.
  assign mag        = aligned + {64'h0000_0000_0000_0000, inc};
  assign signed_val = sign ? (~mag + 65'h0_0000_0000_0000_0001) : mag;

  // Range checks on the signed 65-bit value.
  assign dw_oor  = signed_val[64] ^ signed_val[63];
  assign w_oor   = !((&signed_val[64:31]) || !(|signed_val[64:31]));
  assign oor     = req.word ? w_oor : dw_oor;
  assign invalid = is_special || is_big || oor;

  // Saturated defaults: NaN and negative give the minimum, positive the maximum.
  assign dw_default = (is_snan || is_qnan || sign) ? DW_MIN : DW_MAX;
  assign w_default  = (is_snan || is_qnan || sign) ? W_MIN : W_MAX;

  // Destination value for the chosen width.
  always_comb
  begin
    if (req.word)
      conv_data = {W_UPPER_FILL, invalid ? w_default : signed_val[31:0]};
    else
      conv_data = invalid ? dw_default : signed_val[63:0];
  end

  // Invalid operands clear rounded and inexact.
  assign conv_rounded = !invalid && inc;
  assign conv_inexact = !invalid && (gbit || rbit || xbit);

  assign exec = req.valid && float_unit_enable;

  // A nonzero magnitude with the sign set must come out negative after negation.
  assign neg_nonzero = sign && (aligned != 65'h0_0000_0000_0000_0000);

  // Next-state: register port, then conversion effects on flags and answer.
  always_comb
  begin
    s_d               = s_q;
    s_d.res.valid     = 1'b0;
    s_d.res.write     = 1'b0;
    s_d.res.unavail   = 1'b0;
    s_d.res.cr1_valid = 1'b0;
    s_d.rd_data       = 32'h0000_0000;
    // Reads answer in the next cycle; unmapped offsets read zero.
    if (bus.rd)
    begin
      case (bus.addr)
        ADDR_CTRL:   s_d.rd_data = 32'(s_q.ctrl);
        ADDR_STATUS: s_d.rd_data = {23'h00_0000,
                                    s_q.flags.signaling_nan_invalid_flag | s_q.flags.invalid_convert_flag,
                                    s_q.ctrl.invalid_op_enable &
                                    (s_q.flags.signaling_nan_invalid_flag | s_q.flags.invalid_convert_flag),
                                    s_q.flags};
        default:     s_d.rd_data = 32'h0000_0000;
      endcase
    end
    // Writes to control and to the status flags.
    if (bus.wr && (bus.addr == ADDR_CTRL))
      s_d.ctrl = bus.wdata[2:0];
    if (bus.wr && (bus.addr == ADDR_STATUS))
      s_d.flags = bus.wdata[6:0];
    // A disabled float unit turns the request into an unavailable event.
    if (req.valid && !float_unit_enable)
    begin
      s_d.res.valid   = 1'b1;
      s_d.res.unavail = 1'b1;
    end
    else if (exec)
    begin
      // Flag updates win over a software write in the same cycle.
      s_d.flags.exception_summary_flag = s_d.flags.exception_summary_flag
        | (invalid && !s_d.flags.invalid_convert_flag)
        | (is_snan && !s_d.flags.signaling_nan_invalid_flag)
        | (conv_inexact && !s_d.flags.inexact_sticky);
      s_d.flags.rounded_up_flag            = conv_rounded;
      s_d.flags.inexact_flag               = conv_inexact;
      s_d.flags.inexact_sticky             = s_d.flags.inexact_sticky | conv_inexact;
      s_d.flags.invalid_convert_flag       = s_d.flags.invalid_convert_flag | invalid;
      s_d.flags.signaling_nan_invalid_flag = s_d.flags.signaling_nan_invalid_flag | is_snan;
      s_d.res.valid = 1'b1;
      // Enabled trap on an invalid operand leaves the destination untouched.
      s_d.res.write = !(invalid && s_q.ctrl.invalid_op_enable);
      s_d.res.data  = conv_data;
      if (req.word && req.record_bit)
      begin
        s_d.res.cr1_valid           = 1'b1;
        s_d.res.condition_field_one = {s_d.flags.exception_summary_flag,
                                       s_q.ctrl.invalid_op_enable &
                                       (s_d.flags.invalid_convert_flag | s_d.flags.signaling_nan_invalid_flag),
                                       s_d.flags.invalid_convert_flag | s_d.flags.signaling_nan_invalid_flag,
                                       s_d.flags.overflow_flag};
      end
    end
  end

  // State register; clock enable freezes everything. No result class field is kept.
  always_ff @(posedge clk or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
      s_q <= STATE_RESET;
    else if (clk_en)
      s_q <= s_d;
  end

  assign res          = s_q.res;
  assign status_flags = s_q.flags;
  assign rd_data      = s_q.rd_data;

  // Truncating requests never round up.
  AST_TRUNC_NO_INC: assert property (@(posedge clk) disable iff (!rst_sys_n)
    clk_en && exec && req.trunc |=> !s_q.flags.rounded_up_flag)
    else $error("truncating conversion rounded up");

  // Infinity gives invalid-convert with rounded and inexact clear.
  AST_INF_FLAGS: assert property (@(posedge clk) disable iff (!rst_sys_n)
    clk_en && exec && is_inf |=> s_q.flags.invalid_convert_flag && !s_q.flags.rounded_up_flag
                                 && !s_q.flags.inexact_flag)
    else $error("infinity flags wrong");

  // Signaling NaN sets both invalid flags.
  AST_SNAN_FLAGS: assert property (@(posedge clk) disable iff (!rst_sys_n)
    clk_en && exec && is_snan |=> s_q.flags.invalid_convert_flag && s_q.flags.signaling_nan_invalid_flag
                                  && !s_q.flags.inexact_flag)
    else $error("signaling NaN flags wrong");

  // Quiet NaN leaves the signaling flag as it was.
  AST_QNAN_FLAGS: assert property (@(posedge clk) disable iff (!rst_sys_n)
    clk_en && exec && is_qnan && !bus.wr |=> s_q.flags.invalid_convert_flag
      && (s_q.flags.signaling_nan_invalid_flag == $past(s_q.flags.signaling_nan_invalid_flag)))
    else $error("quiet NaN flags wrong");

  // Large finite exponent saturates on the doubleword path.
  AST_LARGE_SAT: assert property (@(posedge clk) disable iff (!rst_sys_n)
    clk_en && exec && is_big && !req.word && !s_q.ctrl.invalid_op_enable
    |=> s_q.res.write && s_q.flags.invalid_convert_flag
        && (s_q.res.data == ($past(sign) ? DW_MIN : DW_MAX)))
    else $error("large operand default wrong");

  // NaN on the word path gives the minimum in the low half.
  AST_WORD_NAN: assert property (@(posedge clk) disable iff (!rst_sys_n)
    clk_en && exec && req.word && (is_snan || is_qnan) && !s_q.ctrl.invalid_op_enable
    |=> s_q.res.write && (s_q.res.data[31:0] == W_MIN))
    else $error("word NaN default wrong");

  // Enabled trap blocks the destination write.
  AST_TRAP_NOWRITE: assert property (@(posedge clk) disable iff (!rst_sys_n)
    clk_en && exec && invalid && s_q.ctrl.invalid_op_enable |=> s_q.res.valid && !s_q.res.write)
    else $error("trapped conversion wrote destination");

  // Disabled float unit answers with unavailable and no write, for one cycle.
  AST_UNAVAIL: assert property (@(posedge clk) disable iff (!rst_sys_n)
    clk_en && req.valid && !float_unit_enable ##1 clk_en && !req.valid
    |-> s_q.res.unavail && !s_q.res.write ##1 !s_q.res.unavail)
    else $error("unavailable answer wrong");

  // Inexact result leaves the sticky inexact flag set.
  AST_STICKY: assert property (@(posedge clk) disable iff (!rst_sys_n)
    clk_en && exec && conv_inexact |=> s_q.flags.inexact_flag && s_q.flags.inexact_sticky)
    else $error("inexact sticky not set");

  // Record bit on a word conversion loads the condition field.
  AST_RECORD: assert property (@(posedge clk) disable iff (!rst_sys_n)
    clk_en && exec && req.word && req.record_bit |=> s_q.res.cr1_valid
      && (s_q.res.condition_field_one[1] == (s_q.flags.invalid_convert_flag
                                             | s_q.flags.signaling_nan_invalid_flag)))
    else $error("condition field not loaded");

  // Exact doubleword conversion neither rounds nor loses the sign of a nonzero magnitude.
  AST_EXACT: assert property (@(posedge clk) disable iff (!rst_sys_n)
    clk_en && exec && !req.word && !invalid && !(gbit || rbit || xbit)
    |=> !s_q.flags.rounded_up_flag && !s_q.flags.inexact_flag
        && (s_q.res.data[63] == $past(neg_nonzero)))
    else $error("exact conversion changed");

endmodule : ftic_convert

// ### ftic_pipe_model.sv
`timescale 1ns/100ps
// Stands in for the issuing pipeline: it drives one conversion request at a time.
module ftic_pipe_model (
  input  wire logic          clk,
  output ftic_pkg::ftic_req_t req,
  output logic               float_unit_enable
);
  import ftic_pkg::*;

  // Idle request and an available float unit at time zero.
  initial
  begin
    req = '0;
    float_unit_enable = 1'b1;
  end

  // Holds the request over the taking edge, then drops it and scrambles the operand lines.
  task automatic issue(input logic [63:0] op, input logic wd, input logic tr, input logic rc, input logic fue);
    @(posedge clk);
    req <= '{valid: 1'b1, word: wd, trunc: tr, record_bit: rc, operand: op};
    float_unit_enable <= fue;
    @(posedge clk);
    req.valid <= 1'b0;
    req.operand <= ~op; // Released lines do not keep their last value.
  endtask : issue
endmodule : ftic_pipe_model

// ### ftic_pkg.sv
package ftic_pkg;

  // Operand and result widths.
  localparam int DW = 64;
  localparam int WW = 32;

  // Exponent thresholds: all ones marks infinity or NaN, above the limit is out of range.
  localparam logic [10:0] EXP_ALL_ONES = 11'h7ff;
  localparam logic [10:0] EXP_LARGE    = 11'h43e;

  // Right shift before rounding is 1086 - exponent, or 1085 for a denormal, clamped.
  localparam logic [11:0] SHIFT_BASE   = 12'h43e;
  localparam logic [11:0] SHIFT_DENORM = 12'h43d;
  localparam logic [11:0] SHIFT_MAX    = 12'h044;

  // Rounding mode encodings.
  localparam logic [1:0] RM_NEAREST = 2'h0;
  localparam logic [1:0] RM_ZERO    = 2'h1;
  localparam logic [1:0] RM_UP      = 2'h2;
  localparam logic [1:0] RM_DOWN    = 2'h3;

  // Saturated defaults and the fill of the unused upper word half.
  localparam logic [63:0] DW_MAX       = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] DW_MIN       = 64'h8000_0000_0000_0000;
  localparam logic [31:0] W_MAX        = 32'h7fff_ffff;
  localparam logic [31:0] W_MIN        = 32'h8000_0000;
  localparam logic [31:0] W_UPPER_FILL = 32'h0000_0000;

  // Register offsets.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // Conversion request from the pipeline.
  typedef struct packed {
    logic          valid;
    logic          word;
    logic          trunc;
    logic          record_bit;
    logic [DW-1:0] operand;
  } ftic_req_t;

  // Conversion answer to the pipeline.
  typedef struct packed {
    logic          valid;
    logic          write;
    logic [DW-1:0] data;
    logic          unavail;
    logic          cr1_valid;
    logic [3:0]    condition_field_one;
  } ftic_res_t;

  // Register port.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ftic_bus_t;

  // Control register, bits [2:0] of the control word.
  typedef struct packed {
    logic       invalid_op_enable;
    logic [1:0] rounding_mode_field;
  } ftic_ctrl_t;

  // Status flags, bits [6:0] of the status word.
  typedef struct packed {
    logic exception_summary_flag;
    logic overflow_flag;
    logic signaling_nan_invalid_flag;
    logic invalid_convert_flag;
    logic inexact_sticky;
    logic inexact_flag;
    logic rounded_up_flag;
  } ftic_flags_t;

  // Whole state of the converter.
  typedef struct packed {
    ftic_ctrl_t  ctrl;
    ftic_flags_t flags;
    ftic_res_t   res;
    logic [31:0] rd_data;
  } ftic_state_t;

  localparam ftic_state_t STATE_RESET = '0;

endpackage : ftic_pkg
